// ### test/mtt_checker.sv
// port assertions for the test and timing block
// assumes it is bound onto mtt_top with clk_i and rst_i
`include "mtt_defines.svh"
`default_nettype none
module mtt_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        tx_sym_tick_i,
  input wire logic        tx_pre_phase_i,
  input wire logic        tx_sym_vld_o,
  input wire logic        tx_done_o,
  input wire logic        tx_tail_o,
  input wire logic        cal_sample_o,
  input wire logic        cal_busy_o,
  input wire logic [3:0]  gpio_o,
  input wire logic [3:0]  gpio_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ans;
    ack_o ##1 !ack_o;
  endsequence
  bus_answer_a: assert property (s_req |=> s_ans)
    else $error("bus answer missing");
  idle_data_a: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  done_pulse_a: assert property (tx_done_o |=> !tx_done_o)
    else $error("done pulse too long");
  tail_pulse_a: assert property (tx_tail_o |=> !tx_tail_o)
    else $error("tail pulse too long");
  logic [2:0] mode_r;
  // mirror of the mode register: symbols are only due in sending modes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= 3'h0;
    end else if (cyc_i && stb_i && we_i && !ack_o && sel_i[0] &&
                 adr_i == `MTT_OFS_MODE && dat_i[2:0] != 3'h7) begin
      mode_r <= dat_i[2:0];
    end
  end
  sequence s_sym_due;
    tx_sym_tick_i && (mode_r == 3'h1 || mode_r == 3'h2 ||
                      (mode_r == 3'h0 && tx_pre_phase_i));
  endsequence
  sym_valid_a: assert property (s_sym_due |=> tx_sym_vld_o)
    else $error("symbol not issued");
  vld_cause_a: assert property (tx_sym_vld_o |-> $past(tx_sym_tick_i))
    else $error("symbol without tick");
  cal_sample_a: assert property (cal_sample_o |-> $past(cal_busy_o))
    else $error("sample while idle");
  gpio_drive_a: assert property ((gpio_o & ~gpio_oe_o) == 4'h0)
    else $error("pulse on undriven pin");
  gpio_pulse_a: assert property (|gpio_o |=> gpio_o == 4'h0)
    else $error("trigger pulse too long");
endmodule : mtt_checker
bind mtt_top mtt_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .tx_sym_tick_i(tx_sym_tick_i),
  .tx_pre_phase_i(tx_pre_phase_i),
  .tx_sym_vld_o(tx_sym_vld_o), .tx_done_o(tx_done_o),
  .tx_tail_o(tx_tail_o), .cal_sample_o(cal_sample_o),
  .cal_busy_o(cal_busy_o), .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o));
`default_nettype wire

// ### test/mtt_radio_model.sv
// receive front end and symbol timing seen by the block
// assumes one clock; samples change every cycle
`default_nettype none
module mtt_radio_model
  import mtt_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic lock_i,
  output mtt_iq_t   rrc_o,
  output mtt_iq_t   chf_o,
  output mtt_iq_t   dc_o,
  output mtt_iq_t   norm_o,
  output logic      tick_o,
  output logic      inst_o,
  output logic      sync_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] s_r;
  logic [2:0]  c_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= 32'he3ba;
      c_r <= 3'h0;
    end else begin
      s_r <= s_r ^ (s_r << 13) ^ ((s_r ^ (s_r << 13)) >> 17);
      c_r <= c_r + 3'h1;
    end
  end
  assign rrc_o  = s_r[19:0];
  assign chf_o  = s_r[31:12];
  assign dc_o   = ~s_r[19:0];
  assign norm_o = {s_r[9:0], s_r[29:20]};
  assign tick_o = (c_r == 3'h0) && !rst_i;
  assign inst_o = (c_r == 3'h4) && !rst_i;
  // sync only while locked, so no level before sync
  assign sync_o = lock_i;
endmodule : mtt_radio_model
`default_nettype wire

// ### test/tb.sv
// self-checking bench for mtt_top, small symbol period
// assumes mtt_radio_model supplies receive samples and ticks
`include "mtt_defines.svh"
`default_nettype none
module tb;
  import mtt_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SYM = 20;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, lock = 0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q, rs = 32'he3ba;
  logic ack_o, tick, inst, sync, vld, tdone, ttail, tend, csmp, cbusy;
  logic tx_data_end_i = 0, tx_tail_end_i = 0, pre = 0;
  logic [15:0] left = 16'h0;
  logic [5:0] sym;
  logic [3:0] cstg, gpio, gpio_oe;
  mtt_iq_t rrc, chf, dc, nrm, iq;
  int errors = 0, total_checks = 0, cyc_cnt = 0;
  bit bq[$];
  always #25 clk_i = ~clk_i;
  mtt_radio_model u_rad (.clk_i(clk_i), .rst_i(rst_i), .lock_i(lock),
    .rrc_o(rrc), .chf_o(chf), .dc_o(dc), .norm_o(nrm), .tick_o(tick),
    .inst_o(inst), .sync_o(sync));
  mtt_top #(.SYM_CYCLES(SYM)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .tx_sym_tick_i(tick), .tx_pre_phase_i(pre), .tx_syms_left_i(left),
    .tx_data_end_i(tx_data_end_i), .tx_tail_end_i(tx_tail_end_i),
    .rrc_iq_i(rrc), .chf_iq_i(chf), .dc_iq_i(dc), .norm_iq_i(nrm),
    .frame_sync_i(sync), .sym_inst_i(inst), .tx_sym_o(sym),
    .tx_sym_vld_o(vld), .tx_done_o(tdone), .tx_tail_o(ttail),
    .tx_end_seq_o(tend), .cal_stage_o(cstg), .cal_sample_o(csmp),
    .cal_busy_o(cbusy), .iq_out_o(iq), .gpio_o(gpio), .gpio_oe_o(gpio_oe));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  task automatic give_verdict;
    $display("errors %0d total_checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // hold the request until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hf};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask : wb
  task automatic ind(input logic leg, input logic [15:0] dly, input bit tl);
    int n, e;
    wb(1, `MTT_OFS_TIMING, leg ? 32'hfffe : 32'hfffc);
    wb(1, `MTT_OFS_DONE_DLY, {16'h0, dly});
    @(posedge clk_i) {tx_tail_end_i, tx_data_end_i} <= tl ? 2'b10 : 2'b01;
    @(posedge clk_i) {tx_tail_end_i, tx_data_end_i} <= 2'b00;
    n = 1;
    while ((tl ? ttail : tdone) !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    e = (leg ? 83 : dly * 12 + 1) * (SYM / 10);
    chk(n >= e - 4 && n <= e + 4, 1);
  endtask : ind
  task automatic cal(input logic [8:0] en, input logic b0);
    mtt_cal_t cs[9] = '{CS_SETUP, CS_REFI, CS_REFQ, CS_ILO, CS_QLO,
                        CS_HIGH, CS_QHI, CS_IHI, CS_RESTORE};
    logic [3:0] got[$], ex[$], pv;
    int n, t;
    for (int i = 0; i < 9; i++) begin
      if (i == 0 || i == 8 || en[i]) ex.push_back(cs[i]);
    end
    // earlier indications leave flags set; start clean
    wb(1, `MTT_OFS_STATUS, 32'h3);
    wb(1, `MTT_OFS_TIMING, b0 ? 32'hfffd : 32'hfffc);
    wb(1, `MTT_OFS_CAL, {1'b1, 22'h0, en});
    n = 0;
    t = 0;
    pv = cstg;
    while (cbusy === 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
      // the sample pulse comes with the step, so log the stage before it
      if (csmp === 1'b1) begin
        if (got.size() == 0) t = n;
        got.push_back(pv);
      end
      pv = cstg;
    end
    chk(got.size(), ex.size());
    foreach (ex[i]) chk(got[i], ex[i]);
    n = (b0 ? 83 : 13) * (SYM / 10);
    chk(t >= n - 4 && t <= n + 4, 1);
    wb(0, `MTT_OFS_STATUS, 0);
    chk(q[2:0], 3'h1);
    wb(1, `MTT_OFS_STATUS, 32'h3);
    wb(0, `MTT_OFS_STATUS, 0);
    chk(q[1:0], 2'h0);
  endtask : cal
  task automatic syms(input int n);
    bq.delete();
    while (bq.size() < n && cyc_cnt < 50000) begin
      @(posedge clk_i);
      if (vld === 1'b1) begin
        bq.push_back(sym[1]);
        bq.push_back(sym[0]);
      end
    end
  endtask : syms
  task automatic rx(input logic [2:0] m);
    mtt_iq_t p, h;
    wb(1, `MTT_OFS_MODE, {29'h0, m});
    h = '0;
    repeat (2) @(posedge clk_i);
    for (int k = 0; k < 40; k++) begin
      @(posedge clk_i);
      // held sample is unknown until one symbol instant has passed
      if (k > 9) chk(iq, p);
      p = m == 3 ? rrc : m == 4 ? chf : m == 5 ? (inst ? dc : chf) : h;
      if (sync !== 1'b1) h = '0;
      else if (inst) h = nrm;
    end
  endtask : rx
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 60000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    logic [8:0] ex[7] = '{0, 0, 5, 0, 9'hcc, 9'h1ff, 0};
    logic [7:0] pt, ok;
    int c;
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    wb(1, 8'h20, 32'hffff);
    foreach (ex[i]) begin
      wb(0, (i == 6) ? 8'h20 : 8'(i * 4), 0);
      chk(q, ex[i]);
    end
    ind(0, 5, 0);
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      ind(i[0], rs[2:0], i[1]);
    end
    cal(9'h000, 0);
    cal(9'h1e1, 1);
    cal(9'h1ff, 0);
    wb(1, `MTT_OFS_END_OFS, 3);
    for (int i = 0; i < 2; i++) begin
      left <= i ? 16'h0 : 16'h3;
      c = 0;
      // one pulse may still come from the previous count
      @(posedge clk_i);
      repeat (20) @(posedge clk_i) c += (tend === 1'b1);
      chk(c > 0, !i);
    end
    wb(1, `MTT_OFS_MODE, 1);
    syms(1200);
    c = 0;
    for (int k = 0; k < 511; k++) c += bq[k];
    chk(c, 256);
    for (int k = 0; k < 600; k++) chk(bq[k], bq[k+511]);
    rs = xs(rs);
    pt = rs[7:0];
    wb(1, `MTT_OFS_PREAMBLE, {24'h0, pt});
    for (int j = 0; j < 2; j++) begin
      // second pass: normal mode during the preamble phase of a burst
      wb(1, `MTT_OFS_MODE, j ? 32'h0 : 32'h2);
      pre <= j[0];
      syms(24);
      for (int k = 0; k < 8; k++) ok[7-k] = bq[k+8];
      c = 0;
      for (int r = 0; r < 8; r += 2) c += (({pt, pt} << r) >> 8) == ok;
      chk(c > 0, 1);
    end
    pre <= 0;
    rx(3);
    rx(4);
    rx(5);
    rx(6);
    lock <= 1;
    rx(6);
    wb(1, `MTT_OFS_MODE, 7);
    wb(0, `MTT_OFS_MODE, 0);
    chk(q[2:0], 6);
    wb(1, `MTT_OFS_GPIO, 32'h12);
    c = 0;
    repeat (100) @(posedge clk_i) c += (gpio[2] === 1'b1);
    chk(gpio_oe, 4'h4);
    chk(c, 100 / SYM);
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// ### verilog/mtt_defines.svh
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit classic wishbone slave with word-aligned registers
`ifndef MTT_DEFINES_SVH
`define MTT_DEFINES_SVH
`define MTT_OFS_MODE       8'h00
`define MTT_OFS_TIMING     8'h04
`define MTT_OFS_DONE_DLY   8'h08
`define MTT_OFS_END_OFS    8'h0c
`define MTT_OFS_PREAMBLE   8'h10
`define MTT_OFS_CAL        8'h14
`define MTT_OFS_STATUS     8'h18
`define MTT_OFS_GPIO       8'h1c
`define MTT_TM_SMP_DLY_BIT 0
`define MTT_TM_IND_BIT     1
`define MTT_CAL_START_BIT  31
`define MTT_RST_TIMING     16'hfffc
`define MTT_RST_DONE_DLY   16'h0005
`define MTT_RST_END_OFS    16'h0000
`define MTT_RST_PREAMBLE   8'hcc
`define MTT_RST_STAGE_EN   9'h1ff
`define MTT_RST_PRBS       9'h1ff
// delays in tenths of a symbol time
`define MTT_SMP_MIN_TENTHS 8'd12
`define MTT_SMP_LEG_TENTHS 8'd82
`define MTT_DONE_UNIT      20'd12
`define MTT_LEG_DONE_TEN   20'd82
`endif

// ### verilog/mtt_pkg.sv
// types shared by the modem test and timing block
// assumes mtt_defines.svh holds the numeric constants
`default_nettype none
package mtt_pkg;
  typedef enum logic [2:0] {
    MD_TX_NORMAL  = 3'h0,
    MD_TX_PRBS    = 3'h1,
    MD_TX_PREREP  = 3'h2,
    MD_RX_CONST   = 3'h3,
    MD_RX_DIAG    = 3'h4,
    MD_RX_DIAG_DC = 3'h5,
    MD_RX_NORM    = 3'h6
  } mtt_mode_t;
  typedef enum logic [3:0] {
    CS_IDLE    = 4'h0,
    CS_SETUP   = 4'h1,
    CS_REFI    = 4'h3,
    CS_REFQ    = 4'h2,
    CS_ILO     = 4'h6,
    CS_QLO     = 4'h7,
    CS_HIGH    = 4'h5,
    CS_QHI     = 4'h4,
    CS_IHI     = 4'hc,
    CS_RESTORE = 4'hd
  } mtt_cal_t;
  typedef struct packed {
    logic [9:0] i;
    logic [9:0] q;
  } mtt_iq_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    mtt_mode_t   mode;
    logic [1:0]  modsel;
    logic [15:0] tmode;
    logic [15:0] done_dly;
    logic [15:0] end_ofs;
    logic [7:0]  pre_pat;
    logic [8:0]  stage_en;
    logic [3:0]  iters;
    logic [1:0]  gpio_sel;
    logic        gpio_en;
    logic [15:0] tenth_cnt;
    logic [15:0] sym_cnt;
    mtt_cal_t    cal_st;
    logic        busy;
    logic [7:0]  cal_wait;
    logic [3:0]  cal_iter;
    logic        cal_smp;
    logic        done_pend;
    logic [19:0] done_cnt;
    logic        tail_pend;
    logic [19:0] tail_cnt;
    logic        done_flag;
    logic        tail_flag;
    logic        done_pls;
    logic        tail_pls;
    logic        end_seq;
    logic [8:0]  prbs;
    logic [7:0]  pre_rot;
    logic [5:0]  tx_sym;
    logic        tx_vld;
    mtt_iq_t     iq;
    mtt_iq_t     norm;
    logic [3:0]  gpio;
    logic [3:0]  gpio_oe;
  } mtt_state_t;
endpackage : mtt_pkg
`default_nettype wire

// ### verilog/mtt_top.sv
// transmit timing, calibration sequencing and test/diagnostic modes
// assumes a classic wishbone master on clk_i and synchronous inputs
// What this block does
// [R01] setup and restore stages always run
// [R02] host pairs high-gain error stages with switch
// [R03] timing bit0 picks 1.2 or 8.2 sample delay
// [R04] timing bit1 low: tight programmable indication timing
// [R05] timing bit1 high: fixed legacy indication delay
// [R06] host writes ones to reserved timing bits
// [R07] done delay counts in 1.2 symbol steps
// [R08] default done delay matches filter end
// [R09] end sequence starts offset symbols earlier
// [R10] preamble repeats programmed eight-bit pattern
// [R11] test mode: prbs or repeated preamble
// [R12] 511-bit prbs mapped per modulation
// [R13] constellation mode outputs rrc filtered iq
// [R14] gpio emits nominal symbol rate pulses
// [R15] diagnostic mode outputs channel filtered iq
// [R16] dc correction shown as centre point
// [R17] normalised output only after frame sync
// [R18] normalised samples taken already corrected
// [R19] low-gain q stage reads and adjusts q
// [R20] calibration end raises transmit done
// [R21] one mode held until host changes it
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`include "mtt_defines.svh"
`default_nettype none
module mtt_top
  import mtt_pkg::*;
#(
  parameter int SYM_CYCLES = 833
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        tx_sym_tick_i,
  input  wire logic        tx_pre_phase_i,
  input  wire logic [15:0] tx_syms_left_i,
  input  wire logic        tx_data_end_i,
  input  wire logic        tx_tail_end_i,
  input  wire mtt_iq_t     rrc_iq_i,
  input  wire mtt_iq_t     chf_iq_i,
  input  wire mtt_iq_t     dc_iq_i,
  input  wire mtt_iq_t     norm_iq_i,
  input  wire logic        frame_sync_i,
  input  wire logic        sym_inst_i,
  output logic      [5:0]  tx_sym_o,
  output logic             tx_sym_vld_o,
  output logic             tx_done_o,
  output logic             tx_tail_o,
  output logic             tx_end_seq_o,
  output logic      [3:0]  cal_stage_o,
  output logic             cal_sample_o,
  output logic             cal_busy_o,
  output mtt_iq_t          iq_out_o,
  output logic      [3:0]  gpio_o,
  output logic      [3:0]  gpio_oe_o
);

  localparam logic [15:0] TENTH_CYC = 16'(SYM_CYCLES / 10);
  localparam logic [15:0] SYM_CYC   = 16'(SYM_CYCLES);
  generate
    if (SYM_CYCLES < 20 || SYM_CYCLES > 65535) begin : g_chk
      $error("mtt_top: SYM_CYCLES out of range");
    end
  endgenerate
  mtt_state_t r;
  mtt_state_t nx;
  // stage order as an index, so skipping stages is a search
  function automatic mtt_cal_t idx2st(input logic [3:0] k);
    mtt_cal_t s;
    unique case (k)
      4'h0: s = CS_SETUP;
      4'h1: s = CS_REFI;
      4'h2: s = CS_REFQ;
      4'h3: s = CS_ILO;
      4'h4: s = CS_QLO;
      4'h5: s = CS_HIGH;
      4'h6: s = CS_QHI;
      4'h7: s = CS_IHI;
      4'h8: s = CS_RESTORE;
      default: s = CS_IDLE;
    endcase
    return s;
  endfunction : idx2st

  function automatic logic [3:0] st2idx(input mtt_cal_t s);
    logic [3:0] k;
    k = 4'h9;
    for (int j = 0; j < 9; j++) begin
      if (idx2st(4'(j)) == s) begin
        k = 4'(j);
      end
    end
    return k;
  endfunction : st2idx

  // first enabled stage at or after index k (restore is always enabled)
  function automatic logic [3:0] next_en(input logic [3:0] k,
                                         input logic [8:0] en);
    logic [3:0] f;
    logic       hit;
    f   = 4'h8;
    hit = 1'b0;
    for (int j = 0; j < 9; j++) begin
      if (!hit && 4'(j) >= k && en[j]) begin
        f   = 4'(j);
        hit = 1'b1;
      end
    end
    return f;
  endfunction : next_en

  logic [8:0]  en_eff;
  logic [3:0]  cur_k;
  logic [3:0]  nxt_k;
  logic [7:0]  smp_dly;
  logic        tenth;
  logic        wr;
  logic        rd;
  logic [2:0]  bps;
  logic [31:0] wd;

  always_comb begin
    nx     = r;
    // [R01] setup and restore forced
    en_eff = r.stage_en | 9'h101;
    cur_k  = st2idx(r.cal_st);
    nxt_k  = 4'h0;
    // [R03] sample delay select
    smp_dly = r.tmode[`MTT_TM_SMP_DLY_BIT] ? `MTT_SMP_LEG_TENTHS
                                           : `MTT_SMP_MIN_TENTHS;
    tenth = (r.tenth_cnt == 16'h0);
    wr    = cyc_i && stb_i && we_i && !r.ack;
    rd    = cyc_i && stb_i && !we_i && !r.ack;
    wd    = dat_i & {{8{sel_i[3]}}, {8{sel_i[2]}},
                     {8{sel_i[1]}}, {8{sel_i[0]}}};
    unique case (r.modsel)
      2'h1:    bps = 3'd4;
      2'h2:    bps = 3'd6;
      default: bps = 3'd2;
    endcase

    nx.ack      = cyc_i && stb_i && !r.ack;
    nx.tenth_cnt = tenth ? TENTH_CYC - 16'h1 : r.tenth_cnt - 16'h1;
    nx.cal_smp  = 1'b0;
    nx.done_pls = 1'b0;
    nx.tail_pls = 1'b0;
    nx.tx_vld   = 1'b0;

    // register writes; a bad mode code is ignored
    if (wr) begin
      unique case (adr_i)
        `MTT_OFS_MODE: begin
          // [R21] mode held until rewritten
          if (sel_i[0] && wd[2:0] != 3'h7) begin
            nx.mode = mtt_mode_t'(wd[2:0]);
          end
          if (sel_i[0]) begin
            nx.modsel = wd[5:4];
          end
        end
        `MTT_OFS_TIMING:   nx.tmode    = wd[15:0];
        `MTT_OFS_DONE_DLY: nx.done_dly = wd[15:0];
        `MTT_OFS_END_OFS:  nx.end_ofs  = wd[15:0];
        `MTT_OFS_PREAMBLE: begin
          nx.pre_pat = wd[7:0];
          nx.pre_rot = wd[7:0];
        end
        `MTT_OFS_CAL: begin
          nx.stage_en = wd[8:0];
          nx.iters    = wd[15:12];
          if (wd[`MTT_CAL_START_BIT] && r.cal_st == CS_IDLE) begin
            nx.cal_st   = CS_SETUP;
            nx.cal_wait = smp_dly;
            nx.cal_iter = wd[15:12];
          end
        end
        `MTT_OFS_STATUS: begin
          if (wd[0]) nx.done_flag = 1'b0;
          if (wd[1]) nx.tail_flag = 1'b0;
        end
        `MTT_OFS_GPIO: begin
          nx.gpio_sel = wd[1:0];
          nx.gpio_en  = wd[4];
        end
        default: ;
      endcase
    end

    // unmapped and write-only addresses read as zero
    nx.dat = 32'h0;
    if (rd) begin
      unique case (adr_i)
        `MTT_OFS_MODE:     nx.dat = {26'h0, r.modsel, 1'b0, r.mode};
        `MTT_OFS_DONE_DLY: nx.dat = {16'h0, r.done_dly};
        `MTT_OFS_END_OFS:  nx.dat = {16'h0, r.end_ofs};
        `MTT_OFS_PREAMBLE: nx.dat = {24'h0, r.pre_pat};
        `MTT_OFS_CAL:      nx.dat = {16'h0, r.iters, 3'h0, r.stage_en};
        `MTT_OFS_STATUS:   nx.dat = {24'h0, r.cal_st, frame_sync_i,
                                     r.cal_st != CS_IDLE, r.tail_flag,
                                     r.done_flag};
        `MTT_OFS_GPIO:     nx.dat = {27'h0, r.gpio_en, 2'h0, r.gpio_sel};
        default:           nx.dat = 32'h0;
      endcase
    end

    // calibration sequencer, one sample per stage after the delay
    if (r.cal_st != CS_IDLE && tenth) begin
      if (r.cal_wait != 8'h0) begin
        nx.cal_wait = r.cal_wait - 8'h1;
      end else begin
        // [R19] q low-gain stage sampled after settling
        nx.cal_smp  = 1'b1;
        nx.cal_wait = smp_dly;
        nxt_k = next_en(cur_k + 4'h1, en_eff);
        if ((cur_k == 4'h3 || cur_k == 4'h4) && nxt_k > 4'h4 &&
            r.cal_iter != 4'h0) begin
          nx.cal_iter = r.cal_iter - 4'h1;
          nxt_k = next_en(4'h3, en_eff);
        end else if ((cur_k == 4'h6 || cur_k == 4'h7) && nxt_k > 4'h7 &&
                     r.cal_iter != 4'h0) begin
          nx.cal_iter = r.cal_iter - 4'h1;
          nxt_k = next_en(4'h6, en_eff);
        end else if (cur_k == 4'h4 || cur_k == 4'h3) begin
          nx.cal_iter = r.iters;
        end
        if (r.cal_st == CS_RESTORE) begin
          nx.cal_st = CS_IDLE;
          // [R20] calibration end signals done
          nx.done_pls  = 1'b1;
          nx.done_flag = 1'b1;
        end else begin
          nx.cal_st = idx2st(nxt_k);
        end
      end
    end

    // indication delays, counted in tenth-symbol ticks
    if (r.done_pend && tenth) begin
      if (r.done_cnt == 20'h0) begin
        nx.done_pend = 1'b0;
        nx.done_pls  = 1'b1;
        nx.done_flag = 1'b1;
      end else begin
        nx.done_cnt = r.done_cnt - 20'h1;
      end
    end
    if (r.tail_pend && tenth) begin
      if (r.tail_cnt == 20'h0) begin
        nx.tail_pend = 1'b0;
        nx.tail_pls  = 1'b1;
        nx.tail_flag = 1'b1;
      end else begin
        nx.tail_cnt = r.tail_cnt - 20'h1;
      end
    end
    if (tx_data_end_i) begin
      nx.done_pend = 1'b1;
      // [R04] programmable delay, tenth-symbol jitter
      // [R07] units of 1.2 symbols
      // [R05] legacy fixed delay
      nx.done_cnt = r.tmode[`MTT_TM_IND_BIT] ? `MTT_LEG_DONE_TEN
                    : 20'(r.done_dly) * `MTT_DONE_UNIT;
    end
    if (tx_tail_end_i) begin
      nx.tail_pend = 1'b1;
      nx.tail_cnt  = r.tmode[`MTT_TM_IND_BIT] ? `MTT_LEG_DONE_TEN
                     : 20'(r.done_dly) * `MTT_DONE_UNIT;
    end

    // [R09] end sequence earlier by offset
    nx.end_seq = tx_sym_tick_i && tx_syms_left_i == r.end_ofs;

    // transmit symbols, msb first, bits per symbol from modulation
    if (tx_sym_tick_i) begin
      nx.tx_vld = (r.mode == MD_TX_PRBS) || (r.mode == MD_TX_PREREP) ||
                  (r.mode == MD_TX_NORMAL && tx_pre_phase_i);
      nx.tx_sym = 6'h0;
      for (int b = 0; b < 6; b++) begin
        if (3'(b) < bps) begin
          if (r.mode == MD_TX_PRBS) begin
            // [R12] x^9 + x^5 + 1 generator
            nx.tx_sym = {nx.tx_sym[4:0], nx.prbs[8]};
            nx.prbs   = {nx.prbs[7:0], nx.prbs[8] ^ nx.prbs[4]};
          end else begin
            // [R10] repeating preamble pattern
            // [R11] continuous preamble test
            nx.tx_sym  = {nx.tx_sym[4:0], nx.pre_rot[7]};
            nx.pre_rot = {nx.pre_rot[6:0], nx.pre_rot[7]};
          end
        end
      end
      if (!nx.tx_vld) begin
        nx.tx_sym  = 6'h0;
        nx.prbs    = r.prbs;
        nx.pre_rot = r.pre_rot;
      end
    end

    // receive diagnostic output path
    if (!frame_sync_i) begin
      nx.norm = '0;
    end else if (sym_inst_i) begin
      // [R17] sample at symbol instant after sync
      // [R18] input already frequency and gain corrected
      nx.norm = norm_iq_i;
    end
    unique case (r.mode)
      // [R13] rrc filtered iq
      MD_RX_CONST:   nx.iq = rrc_iq_i;
      // [R15] channel filtered iq
      MD_RX_DIAG:    nx.iq = chf_iq_i;
      // [R16] dc estimate one sample per symbol
      MD_RX_DIAG_DC: nx.iq = sym_inst_i ? dc_iq_i : chf_iq_i;
      MD_RX_NORM:    nx.iq = r.norm;
      default:       nx.iq = '0;
    endcase

    // [R14] free-running nominal symbol rate trigger
    nx.sym_cnt = (r.sym_cnt == 16'h0) ? SYM_CYC - 16'h1
                                      : r.sym_cnt - 16'h1;
    nx.gpio    = 4'h0;
    nx.gpio_oe = 4'h0;
    if (r.gpio_en) begin
      nx.gpio_oe[r.gpio_sel] = 1'b1;
      nx.gpio[r.gpio_sel]    = (r.sym_cnt == 16'h0);
    end
    nx.busy    = (nx.cal_st != CS_IDLE);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r          <= '0;
      r.tmode    <= `MTT_RST_TIMING;
      // [R08] default aligns with filter end
      r.done_dly <= `MTT_RST_DONE_DLY;
      r.end_ofs  <= `MTT_RST_END_OFS;
      r.pre_pat  <= `MTT_RST_PREAMBLE;
      r.pre_rot  <= `MTT_RST_PREAMBLE;
      r.stage_en <= `MTT_RST_STAGE_EN;
      r.prbs     <= `MTT_RST_PRBS;
    end else begin
      r <= nx;
    end
  end

  assign dat_o        = r.dat;
  assign ack_o        = r.ack;
  assign tx_sym_o     = r.tx_sym;
  assign tx_sym_vld_o = r.tx_vld;
  assign tx_done_o    = r.done_pls;
  assign tx_tail_o    = r.tail_pls;
  assign tx_end_seq_o = r.end_seq;
  assign cal_stage_o  = r.cal_st;
  assign cal_sample_o = r.cal_smp;
  assign cal_busy_o   = r.busy;
  assign iq_out_o     = r.iq;
  assign gpio_o       = r.gpio;
  assign gpio_oe_o    = r.gpio_oe;

endmodule : mtt_top
`default_nettype wire
